/* core/mmsu_top.sv */
// Execution unit for multiply, accumulate, special moves and sync
`timescale 1ns/1ps
`include "mmsu_defines.svh"
module mmsu_top
    import mmsu_pkg::*;
(
    // Clock and reset
    input  wire logic          clock_in,
    input  wire logic          rstn_in,
    // Issue from decoder and register file
    input  wire mmsu_issue_t   issue_in,
    input  wire logic          range_en_in,
    input  wire logic          mem_pending_in,
    // Special-register port
    input  wire logic          spr_ack_in,
    input  wire logic   [31:0] spr_rdata_in,
    output mmsu_spr_req_t      spr_out,
    // Results
    output mmsu_wb_t           wb_out,
    output logic               stall_out,
    output logic               overflow_flag_out,
    output logic               carry_flag_out,
    output logic               range_exc_out
);
    mmsu_state_t        state_q;
    mmsu_state_t        state_d;
    mmsu_acc_job_t      job_q;
    mmsu_acc_job_t      job_d;
    mmsu_spr_req_t      spr_q;
    mmsu_spr_req_t      spr_d;
    mmsu_wb_t           wb_q;
    mmsu_wb_t           wb_d;
    logic        [4:0]  dest_q;
    logic        [4:0]  dest_d;
    logic        [31:0] wdata_q;
    logic        [31:0] wdata_d;
    logic               stall_q;
    logic               ov_q;
    logic               ov_d;
    logic               cy_q;
    logic               cy_d;
    logic               rexc_q;
    logic               rexc_d;
    logic               mac_go;
    logic        [31:0] mac_b;
    logic               acc_clear;
    logic               acc_wr_lo;
    logic               acc_wr_hi;
    logic        [63:0] acc;
    logic               pipe_busy;

    // ****************************************
    // Decode
    // ****************************************
    logic        [5:0]  major;
    logic               is_mac;
    logic               is_msb;
    logic               is_maci;
    logic               is_macrc;
    logic               is_movhi;
    logic               is_mfspr;
    logic               is_mtspr;
    logic               is_mul;
    logic               is_muli;
    logic               is_msync;
    logic               take;
    logic        [31:0] split_imm;
    logic        [31:0] imm16_s;
    logic        [31:0] spr_num;
    logic               spr_lo;
    logic               spr_hi;
    logic        [31:0] mul_b;
    logic signed [63:0] sprod;
    logic        [63:0] uprod;
    logic               mul_ov;
    logic               mul_cy;

    assign major     = issue_in.insn[31:26];
    assign take      = issue_in.valid && (state_q == MMSU_ST_IDLE);
    assign is_mac    = (major == `MMSU_OP_MAC) && (issue_in.insn[3:0] == `MMSU_MIN_MAC);
    assign is_msb    = (major == `MMSU_OP_MAC) && (issue_in.insn[3:0] == `MMSU_MIN_MSB);
    assign is_maci   = (major == `MMSU_OP_MACI);
    assign is_macrc  = (major == `MMSU_OP_MOVHI) && issue_in.insn[`MMSU_MACRC_BIT];
    assign is_movhi  = (major == `MMSU_OP_MOVHI) && !issue_in.insn[`MMSU_MACRC_BIT];
    assign is_mfspr  = (major == `MMSU_OP_MFSPR);
    assign is_mtspr  = (major == `MMSU_OP_MTSPR);
    assign is_mul    = (major == `MMSU_OP_ALU) && (issue_in.insn[9:8] == `MMSU_ALU_SUB3)
                       && (issue_in.insn[3:0] == `MMSU_ALU_MUL);
    assign is_muli   = (major == `MMSU_OP_MULI);
    assign is_msync  = (issue_in.insn == `MMSU_MSYNC_WORD);
    // Split immediate: upper five bits sit in the destination field
    assign split_imm = {{16{issue_in.insn[25]}}, issue_in.insn[25:21], issue_in.insn[10:0]};
    assign imm16_s   = {{16{issue_in.insn[15]}}, issue_in.insn[15:0]};
    assign spr_num   = is_mtspr ? (issue_in.opa | {16'h0, split_imm[15:0]})
                                : (issue_in.opa | {16'h0, issue_in.insn[15:0]});
    assign spr_lo    = (spr_num == `MMSU_SPR_ACC_LO);
    assign spr_hi    = (spr_num == `MMSU_SPR_ACC_HI);
    assign mul_b     = is_muli ? imm16_s : issue_in.opb;
    assign sprod     = $signed(issue_in.opa) * $signed(mul_b);
    assign uprod     = {32'h0, issue_in.opa} * {32'h0, mul_b};
    assign mul_ov    = (sprod[63:32] != {32{sprod[31]}});
    assign mul_cy    = |uprod[63:32];

    // ****************************************
    // Sequencing
    // ****************************************
    always_comb
    begin
        state_d   = state_q;
        job_d     = job_q;
        spr_d     = spr_q;
        dest_d    = dest_q;
        wdata_d   = wdata_q;
        wb_d      = '0;
        ov_d      = ov_q;
        cy_d      = cy_q;
        rexc_d    = 1'b0;
        mac_go    = 1'b0;
        mac_b     = issue_in.opb;
        acc_clear = 1'b0;
        acc_wr_lo = 1'b0;
        acc_wr_hi = 1'b0;
        case (state_q)
            MMSU_ST_IDLE:
            begin
                dest_d = issue_in.insn[25:21];
                if (issue_in.valid)
                begin
                    if (is_mac || is_msb || is_maci)
                    begin
                        mac_go = 1'b1;
                        mac_b  = is_maci ? split_imm : issue_in.opb;
                    end
                    else if (is_movhi)
                        wb_d = {1'b1, issue_in.insn[25:21], issue_in.insn[15:0], 16'h0};
                    else if (is_mul || is_muli)
                    begin
                        wb_d   = {1'b1, issue_in.insn[25:21], sprod[31:0]};
                        ov_d   = mul_ov;
                        cy_d   = mul_cy;
                        rexc_d = mul_ov && range_en_in;
                    end
                    else if (is_macrc)
                    begin
                        state_d = MMSU_ST_ACC;
                        job_d   = '{rd: 1'b1, clr: 1'b1, hi: 1'b0, wr: 1'b0};
                    end
                    else if ((is_mfspr || is_mtspr) && (spr_lo || spr_hi))
                    begin
                        state_d = MMSU_ST_ACC;
                        job_d   = '{rd: is_mfspr, clr: 1'b0, hi: spr_hi, wr: is_mtspr};
                        wdata_d = issue_in.opb;
                    end
                    else if (is_mfspr || is_mtspr)
                    begin
                        state_d = MMSU_ST_SPR;
                        spr_d   = '{re: is_mfspr, we: is_mtspr, addr: spr_num,
                                    wdata: is_mtspr ? issue_in.opb : 32'h0};
                    end
                    else if (is_msync)
                        state_d = MMSU_ST_SYNC;
                end
            end
            MMSU_ST_ACC:
            begin
                if (!pipe_busy)
                begin
                    if (job_q.rd)
                        wb_d = {1'b1, dest_q, job_q.hi ? acc[63:32] : acc[31:0]};
                    acc_clear = job_q.clr;
                    acc_wr_lo = job_q.wr && !job_q.hi;
                    acc_wr_hi = job_q.wr && job_q.hi;
                    state_d   = MMSU_ST_IDLE;
                end
            end
            MMSU_ST_SPR:
            begin
                if (spr_ack_in)
                begin
                    if (spr_q.re)
                        wb_d = {1'b1, dest_q, spr_rdata_in};
                    spr_d   = '0;
                    state_d = MMSU_ST_IDLE;
                end
            end
            MMSU_ST_SYNC:
            begin
                if (!mem_pending_in)
                    state_d = MMSU_ST_IDLE;
            end
            default:
            begin
                state_d = MMSU_ST_IDLE;
                spr_d   = '0;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_q <= MMSU_ST_IDLE;
            job_q   <= '0;
            spr_q   <= '0;
            dest_q  <= 5'h0;
            wdata_q <= 32'h0;
            wb_q    <= '0;
            stall_q <= 1'b0;
            ov_q    <= 1'b0;
            cy_q    <= 1'b0;
            rexc_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            job_q   <= job_d;
            spr_q   <= spr_d;
            dest_q  <= dest_d;
            wdata_q <= wdata_d;
            wb_q    <= wb_d;
            stall_q <= (state_d != MMSU_ST_IDLE);
            ov_q    <= ov_d;
            cy_q    <= cy_d;
            rexc_q  <= rexc_d;
        end
    end

    mmsu_mac_pipe u_mac_pipe (
        .clock_in    (clock_in),
        .rstn_in     (rstn_in),
        .op_valid_in (mac_go),
        .op_sub_in   (is_msb),
        .op_a_in     (issue_in.opa),
        .op_b_in     (mac_b),
        .clear_in    (acc_clear),
        .wr_lo_in    (acc_wr_lo),
        .wr_hi_in    (acc_wr_hi),
        .wdata_in    (wdata_q),
        .acc_out     (acc),
        .busy_out    (pipe_busy)
    );

    assign spr_out           = spr_q;
    assign wb_out            = wb_q;
    assign stall_out         = stall_q;
    assign overflow_flag_out = ov_q;
    assign carry_flag_out    = cy_q;
    assign range_exc_out     = rexc_q;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_take_mtspr;
        take && is_mtspr && !spr_lo && !spr_hi;
    endsequence

    sequence s_spr_write;
        spr_out.we && !spr_out.re;
    endsequence

    property p_spr_write;
        @(posedge clock_in) disable iff (!rstn_in)
        s_take_mtspr |=> s_spr_write ##0 spr_out.wdata == $past(issue_in.opb)
                         ##0 spr_out.addr == ($past(issue_in.opa) | {16'h0, $past(issue_in.insn[25:21]),
                                                                     $past(issue_in.insn[10:0])});
    endproperty
    a_spr_write: assert property (p_spr_write) else $error("special write wrong");

    property p_movhi;
        @(posedge clock_in) disable iff (!rstn_in)
        take && is_movhi |=> wb_out.valid && wb_out.data == {$past(issue_in.insn[15:0]), 16'h0};
    endproperty
    a_movhi: assert property (p_movhi) else $error("load-high result wrong");

    property p_mul;
        @(posedge clock_in) disable iff (!rstn_in)
        take && is_mul |=> wb_out.valid && wb_out.data == $past(issue_in.opa) * $past(issue_in.opb);
    endproperty
    a_mul: assert property (p_mul) else $error("multiply result wrong");

    property p_acc_wait;
        @(posedge clock_in) disable iff (!rstn_in)
        take && is_macrc && pipe_busy |=> stall_out && !wb_out.valid ##1 wb_out.valid;
    endproperty
    a_acc_wait: assert property (p_acc_wait) else $error("read before pipeline drained");

    property p_macrc_read;
        @(posedge clock_in) disable iff (!rstn_in)
        state_q == MMSU_ST_ACC && !pipe_busy && job_q.rd && job_q.clr
        |=> wb_out.valid && wb_out.data == $past(acc[31:0]) ##1 acc == 64'h0;
    endproperty
    a_macrc_read: assert property (p_macrc_read) else $error("read-and-clear wrong");

    property p_msync;
        @(posedge clock_in) disable iff (!rstn_in)
        state_q == MMSU_ST_SYNC && mem_pending_in |=> stall_out && state_q == MMSU_ST_SYNC;
    endproperty
    a_msync: assert property (p_msync) else $error("sync released early");

    property p_no_exc;
        @(posedge clock_in) disable iff (!rstn_in)
        take && !is_mul && !is_muli |=> !range_exc_out;
    endproperty
    a_no_exc: assert property (p_no_exc) else $error("unexpected exception");

    property p_flags;
        @(posedge clock_in) disable iff (!rstn_in)
        take && is_muli |=> overflow_flag_out == $past(mul_ov) && carry_flag_out == $past(mul_cy)
                            && range_exc_out == ($past(mul_ov) && $past(range_en_in));
    endproperty
    a_flags: assert property (p_flags) else $error("multiply flags wrong");
endmodule

/* inc/mmsu_defines.svh */
// Constants of the multiply, accumulate and special-register move unit
`ifndef MMSU_DEFINES_SVH
`define MMSU_DEFINES_SVH

// Major opcodes
`define MMSU_OP_MAC      6'h31
`define MMSU_OP_MACI     6'h13
`define MMSU_OP_MOVHI    6'h06
`define MMSU_OP_MTSPR    6'h30
`define MMSU_OP_MFSPR    6'h2D
`define MMSU_OP_ALU      6'h38
`define MMSU_OP_MULI     6'h2C
// Minor codes and fields
`define MMSU_MIN_MAC     4'h1
`define MMSU_MIN_MSB     4'h2
`define MMSU_ALU_MUL     4'h6
`define MMSU_ALU_SUB3    2'h3
`define MMSU_MACRC_BIT   16
`define MMSU_MSYNC_WORD  32'h22000000
// Special-register numbers of the accumulator words
`define MMSU_SPR_ACC_LO  32'h00002801
`define MMSU_SPR_ACC_HI  32'h00002802
// Reset values
`define MMSU_ACC_RST     64'h0000000000000000

`endif

/* inc/mmsu_pkg.sv */
// Types of the multiply, accumulate and special-register move unit
package mmsu_pkg;

    typedef struct packed {
        logic        valid;
        logic [31:0] insn;
        logic [31:0] opa;
        logic [31:0] opb;
    } mmsu_issue_t;

    typedef struct packed {
        logic        valid;
        logic [4:0]  dest;
        logic [31:0] data;
    } mmsu_wb_t;

    typedef struct packed {
        logic        re;
        logic        we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mmsu_spr_req_t;

    typedef struct packed {
        logic rd;
        logic clr;
        logic hi;
        logic wr;
    } mmsu_acc_job_t;

    typedef enum logic [3:0] {
        MMSU_ST_IDLE = 4'h1,
        MMSU_ST_ACC  = 4'h2,
        MMSU_ST_SPR  = 4'h4,
        MMSU_ST_SYNC = 4'h8
    } mmsu_state_t;

endpackage

/* core/mmsu_mac_pipe.sv */
// Two-stage multiply-accumulate pipeline holding the accumulator pair
`timescale 1ns/1ps
`include "mmsu_defines.svh"
module mmsu_mac_pipe
    import mmsu_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rstn_in,
    // Operation entry
    input  wire logic        op_valid_in,
    input  wire logic        op_sub_in,
    input  wire logic [31:0] op_a_in,
    input  wire logic [31:0] op_b_in,
    // Accumulator access
    input  wire logic        clear_in,
    input  wire logic        wr_lo_in,
    input  wire logic        wr_hi_in,
    input  wire logic [31:0] wdata_in,
    output logic      [63:0] acc_out,
    output logic             busy_out
);
    logic               s1_valid_q;
    logic               s1_valid_d;
    logic               s1_sub_q;
    logic               s1_sub_d;
    logic        [31:0] s1_prod_q;
    logic        [31:0] s1_prod_d;
    logic        [63:0] acc_q;
    logic        [63:0] acc_d;
    logic signed [63:0] full_prod;
    logic        [63:0] prod_ext;

    always_comb
    begin
        full_prod  = $signed(op_a_in) * $signed(op_b_in);
        s1_valid_d = op_valid_in;
        s1_sub_d   = op_sub_in;
        s1_prod_d  = full_prod[31:0];
        prod_ext   = {{32{s1_prod_q[31]}}, s1_prod_q};
        acc_d      = acc_q;
        if (clear_in)
            acc_d = `MMSU_ACC_RST;
        else if (wr_lo_in)
            acc_d = {acc_q[63:32], wdata_in};
        else if (wr_hi_in)
            acc_d = {wdata_in, acc_q[31:0]};
        else if (s1_valid_q && s1_sub_q)
            acc_d = acc_q - prod_ext;
        else if (s1_valid_q)
            acc_d = acc_q + prod_ext;
    end

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s1_valid_q <= 1'b0;
            s1_sub_q   <= 1'b0;
            s1_prod_q  <= 32'h0;
            acc_q      <= `MMSU_ACC_RST;
        end
        else
        begin
            s1_valid_q <= s1_valid_d;
            s1_sub_q   <= s1_sub_d;
            s1_prod_q  <= s1_prod_d;
            acc_q      <= acc_d;
        end
    end

    assign acc_out  = acc_q;
    assign busy_out = s1_valid_q;

    // ****************************************
    // Checks
    // ****************************************
    sequence s_add_step;
        s1_valid_q && !s1_sub_q && !clear_in && !wr_lo_in && !wr_hi_in;
    endsequence

    property p_acc_add;
        @(posedge clock_in) disable iff (!rstn_in)
        s_add_step |=> acc_q == $past(acc_q) + {{32{$past(s1_prod_q[31])}}, $past(s1_prod_q)};
    endproperty
    a_acc_add: assert property (p_acc_add) else $error("accumulate sum wrong");

    property p_acc_sub;
        @(posedge clock_in) disable iff (!rstn_in)
        op_valid_in && op_sub_in ##1 !clear_in && !wr_lo_in && !wr_hi_in
        |=> acc_q == $past(acc_q) - {{32{$past(s1_prod_q[31])}}, $past(s1_prod_q)};
    endproperty
    a_acc_sub: assert property (p_acc_sub) else $error("subtract result wrong");

    property p_acc_clear;
        @(posedge clock_in) disable iff (!rstn_in)
        clear_in |=> acc_q == 64'h0;
    endproperty
    a_acc_clear: assert property (p_acc_clear) else $error("clear left data");

    property p_prod_trunc;
        @(posedge clock_in) disable iff (!rstn_in)
        op_valid_in |=> s1_prod_q == $past(op_a_in) * $past(op_b_in);
    endproperty
    a_prod_trunc: assert property (p_prod_trunc) else $error("product not truncated");
endmodule

/* verification/mmsu_spr_model.sv */
// Far-side model that answers the unit's special-register requests
`timescale 1ns/1ps
module mmsu_spr_model
    import mmsu_pkg::*;
(
    // Clock and reset
    input  wire logic          clock_in,
    input  wire logic          rstn_in,
    // Request from the unit
    input  wire mmsu_spr_req_t spr_in,
    input  wire logic   [1:0]  delay_in,
    // Answer and record of the last request
    output logic               ack_out,
    output logic        [31:0] rdata_out,
    output logic        [31:0] addr_out,
    output logic        [31:0] wdata_out,
    output logic               wr_out
);
    logic [1:0] cnt_q;

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ack_out   <= 1'b0;
            rdata_out <= 32'h00000000;
            addr_out  <= 32'h00000000;
            wdata_out <= 32'h00000000;
            wr_out    <= 1'b0;
            cnt_q     <= 2'h0;
        end
        else
        begin
            ack_out   <= 1'b0;
            // Read data only valid in the answer cycle
            rdata_out <= ~rdata_out;
            if ((spr_in.re || spr_in.we) && !ack_out)
            begin
                if (cnt_q == delay_in)
                begin
                    ack_out   <= 1'b1;
                    cnt_q     <= 2'h0;
                    rdata_out <= ~spr_in.addr;
                    addr_out  <= spr_in.addr;
                    wdata_out <= spr_in.wdata;
                    wr_out    <= spr_in.we;
                end
                else
                begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end
endmodule

/* verification/mac_multiply_spr_move_unit_tb_top.sv */
// Self-checking testbench of the multiply, accumulate and special move unit
`timescale 1ns/1ps
`include "mmsu_defines.svh"
module mac_multiply_spr_move_unit_tb_top;
    import mmsu_pkg::*;

    logic          clock_in;
    logic          rstn_in;
    mmsu_issue_t   issue;
    logic          range_en;
    logic          mem_pending;
    logic          spr_ack;
    logic   [31:0] spr_rdata;
    mmsu_spr_req_t spr;
    mmsu_wb_t      wb;
    logic          stall;
    logic          ov_flag;
    logic          cy_flag;
    logic          range_exc;
    logic   [1:0]  spr_delay;
    logic   [31:0] spr_addr;
    logic   [31:0] spr_wdata;
    logic          spr_wr;
    int            num_errors;
    int            num_checks;
    int            seed;
    int            i;
    int            r;
    logic   [63:0] acc;
    logic   [31:0] got;
    logic   [31:0] a;
    logic   [31:0] b;
    logic   [31:0] p;
    logic   [15:0] k;
    logic   [4:0]  d;
    logic   [4:0]  got_d;
    logic   [2:0]  got_fl;
    logic          got_st;
    logic   [31:0] insn;

    mmsu_top DUT (.clock_in(clock_in), .rstn_in(rstn_in), .issue_in(issue), .range_en_in(range_en),
        .mem_pending_in(mem_pending), .spr_ack_in(spr_ack), .spr_rdata_in(spr_rdata), .spr_out(spr),
        .wb_out(wb), .stall_out(stall), .overflow_flag_out(ov_flag), .carry_flag_out(cy_flag),
        .range_exc_out(range_exc));

    mmsu_spr_model PARTNER (.clock_in(clock_in), .rstn_in(rstn_in), .spr_in(spr), .delay_in(spr_delay),
        .ack_out(spr_ack), .rdata_out(spr_rdata), .addr_out(spr_addr), .wdata_out(spr_wdata), .wr_out(spr_wr));

    initial clock_in = 1'b0;
    always #25 clock_in = ~clock_in;

    // ****************************************
    // Expectation helpers and bus tasks
    // ****************************************
    function automatic logic [2:0] flags(input logic [31:0] x, input logic [31:0] y, input logic en);
        logic signed [63:0] sp;
        logic        [63:0] up;
        logic               o;
        sp = $signed({{32{x[31]}}, x}) * $signed({{32{y[31]}}, y});
        up = {32'h00000000, x} * {32'h00000000, y};
        o  = (sp[63:32] != {32{sp[31]}});
        return {o, |up[63:32], o & en};
    endfunction

    task automatic chk(input logic [63:0] exp, input logic [63:0] got_v);
        num_checks++;
        if (got_v !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got_v);
        end
    endtask

    task automatic test_done();
        $display("Errors %0d, checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic op(input logic [31:0] ins, input logic [31:0] x, input logic [31:0] y, input logic want_wb);
        int n;
        issue = '{1'b1, ins, x, y};
        @(negedge clock_in);
        issue.valid = 1'b0;
        got_st = stall;
        for (n = 0; n < 20; n++)
        begin
            if (want_wb ? (wb.valid === 1'b1) : (stall === 1'b0))
                break;
            @(negedge clock_in);
        end
        if (n == 20)
        begin
            chk(64'h1, 64'h0);
            test_done();
        end
        got    = wb.data;
        got_d  = wb.dest;
        got_fl = {ov_flag, cy_flag, range_exc};
        @(negedge clock_in);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        issue = '0; range_en = 1'b0; mem_pending = 1'b0; spr_delay = 2'h0;
        num_errors = 0; num_checks = 0; seed = 14; acc = 64'h0; rstn_in = 1'b0;
        repeat (12) @(posedge clock_in);
        @(negedge clock_in);
        rstn_in = 1'b1;
        chk(64'h0, {wb.valid, stall, range_exc});
        for (i = 0; i < 8; i++)
        begin
            k = (i == 0) ? 16'hFFFF : 16'($random(seed));
            d = 5'($random(seed));
            op({`MMSU_OP_MOVHI, d, 5'h00, k}, $random(seed), $random(seed), 1'b1);
            chk({32'h0, k, 16'h0000}, {32'h0, got});
            chk({59'h0, d}, {59'h0, got_d});
            chk(64'h0, {63'h0, got_fl[0]});
        end
        for (i = 0; i < 20; i++)
        begin
            a = (i == 0) ? 32'h7FFFFFFF : (i == 1) ? 32'hFFFFFFFF : $random(seed);
            b = (i < 2) ? 32'h00000002 : $random(seed);
            k = 16'($random(seed));
            d = 5'($random(seed));
            range_en = i[0];
            if (i < 10)
                op({`MMSU_OP_ALU, d, 5'h01, 5'h02, 1'b0, `MMSU_ALU_SUB3, 4'h0, `MMSU_ALU_MUL}, a, b, 1'b1);
            else
            begin
                b = {{16{k[15]}}, k};
                op({`MMSU_OP_MULI, d, 5'h01, k}, a, $random(seed), 1'b1);
            end
            p = a * b;
            chk({32'h0, p}, {32'h0, got});
            chk({61'h0, flags(a, b, range_en)}, {61'h0, got_fl});
        end
        range_en = 1'b1;
        for (r = 0; r < 2; r++)
        begin
            for (i = 0; i < 6; i++)
            begin
                a = $random(seed);
                b = $random(seed);
                k = 16'($random(seed));
                case ($unsigned($random(seed)) % 3)
                    0: insn = {`MMSU_OP_MAC, 22'h0, `MMSU_MIN_MAC};
                    1: insn = {`MMSU_OP_MAC, 22'h0, `MMSU_MIN_MSB};
                    default:
                    begin
                        insn = {`MMSU_OP_MACI, k[15:11], 5'h00, 5'h00, k[10:0]};
                        b = {{16{k[15]}}, k};
                    end
                endcase
                p = a * b;
                if (insn[3:0] == `MMSU_MIN_MSB && insn[31:26] == `MMSU_OP_MAC)
                    acc = acc - {{32{p[31]}}, p};
                else
                    acc = acc + {{32{p[31]}}, p};
                issue = '{1'b1, insn, a, (insn[31:26] == `MMSU_OP_MACI) ? $random(seed) : b};
                @(negedge clock_in);
                chk(64'h0, {63'h0, range_exc});
            end
            if (r == 0)
            begin
                op({`MMSU_OP_MFSPR, 5'h03, 5'h01, 16'h0002}, 32'h00002800, 32'h0, 1'b1);
                chk({32'h0, acc[63:32]}, {32'h0, got});
            end
            op({`MMSU_OP_MOVHI, 5'h07, 5'h01, 16'h0000}, $random(seed), 32'h0, 1'b1);
            chk(64'h1, {63'h0, got_st});
            chk({32'h0, acc[31:0]}, {32'h0, got});
            acc = 64'h0;
            for (i = 1; i < 3; i++)
            begin
                op({`MMSU_OP_MFSPR, 5'h03, 5'h01, 16'(i)}, 32'h00002800, 32'h0, 1'b1);
                chk(64'h0, {32'h0, got});
            end
        end
        for (i = 1; i < 3; i++)
        begin
            b = $random(seed);
            op({`MMSU_OP_MTSPR, 5'h00, 10'h000, 11'(i)}, 32'h00002800, b, 1'b0);
            op({`MMSU_OP_MFSPR, 5'h05, 5'h01, 16'(i)}, 32'h00002800, 32'h0, 1'b1);
            chk({32'h0, b}, {32'h0, got});
        end
        for (i = 0; i < 8; i++)
        begin
            spr_delay = 2'(i);
            a = $random(seed) & 32'hFFFF0000;
            b = $random(seed);
            k = 16'($random(seed));
            if (i < 4)
            begin
                op({`MMSU_OP_MFSPR, 5'h04, 5'h01, k}, a, b, 1'b1);
                chk({32'h0, ~(a | {16'h0, k})}, {32'h0, got});
                chk({32'h0, a | {16'h0, k}}, {32'h0, spr_addr});
            end
            else
            begin
                op({`MMSU_OP_MTSPR, k[15:11], 10'h000, k[10:0]}, a, b, 1'b0);
                chk({31'h0, 1'b1, a | {16'h0, k}}, {31'h0, spr_wr, spr_addr});
                chk({32'h0, b}, {32'h0, spr_wdata});
            end
        end
        mem_pending = 1'b1;
        issue = '{1'b1, `MMSU_MSYNC_WORD, 32'h0, 32'h0};
        @(negedge clock_in);
        issue = '{1'b1, {`MMSU_OP_MOVHI, 5'h02, 5'h00, 16'h1234}, 32'h0, 32'h0};
        for (i = 0; i < 5; i++)
        begin
            @(negedge clock_in);
            chk(64'h2, {62'h0, stall, wb.valid});
        end
        issue.valid = 1'b0;
        mem_pending = 1'b0;
        for (i = 0; i < 4 && stall !== 1'b0; i++)
            @(negedge clock_in);
        chk(64'h0, {63'h0, stall});
        test_done();
    end
endmodule
